// ==== verilog/ifbp_pkg.sv ====
/*
  Constants, types and carriers shared by the fetch front end.
  Assumes a single processor clock domain; nothing else.
*/
package ifbp_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned OPW_W     = 16;
  localparam int unsigned QUEUE_D   = 10;
  localparam int unsigned QPTR_W    = 4;
  localparam int unsigned BC_N      = 8;
  localparam int unsigned BC_IDX_W  = 3;
  localparam int unsigned PT_N      = 128;
  localparam int unsigned PT_IDX_W  = 7;
  localparam int unsigned RS_N      = 4;
  localparam int unsigned RS_PTR_W  = 2;
  localparam int unsigned BUF_D     = 2;
  localparam int unsigned ILLEGAL_VECTOR = 4;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FETCH_STEP = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] RESET_PC   = 32'h0000_0000;
  localparam logic [7:0]        VEC_ILLEGAL = 8'h04;
  localparam int unsigned       IDX_LSB    = 1;
  localparam int unsigned       DISP_MSB   = 7;
  localparam logic [3:0] OP_BCC   = 4'h6;
  localparam logic [3:0] COND_BRA = 4'h0;
  localparam logic [3:0] COND_BSR = 4'h1;
  localparam logic [15:0] OP_RTS  = 16'h4e75;
  localparam logic [15:0] OP_JMP_MSK = 16'hffc0;
  localparam logic [15:0] OP_JMP  = 16'h4ec0;
  localparam logic [15:0] OP_JSR  = 16'h4e80;
  localparam logic [3:0]  OP_ILL_A = 4'ha;
  localparam logic [3:0]  OP_ILL_F = 4'hf;

  // Two-bit prediction states
  typedef enum logic [1:0] {
    IFBP_SNT = 2'b00,
    IFBP_WNT = 2'b01,
    IFBP_WT  = 2'b10,
    IFBP_ST  = 2'b11
  } ifbp_pred_e;
  localparam logic [1:0] PRED_RESET = 2'b01;

  // Fetch control states
  typedef enum logic [1:0] {
    IFBP_RUN   = 2'b01,
    IFBP_FLUSH = 2'b10
  } ifbp_fsm_e;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } ifbp_stage_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [OPW_W-1:0]  opw;
    logic              is_branch;
    logic              pred_taken;
    logic              folded;
    logic              illegal;
    logic [ADDR_W-1:0] target;
  } ifbp_insn_s;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              taken;
    logic              mispredict;
    logic [ADDR_W-1:0] target;
  } ifbp_resolve_s;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] tag;
    logic [1:0]        pred;
    logic [ADDR_W-1:0] target;
  } ifbp_bc_s;
endpackage

// ==== verilog/ifbp_fetch.sv ====
/*
  Instruction fetch front end with two-level branch prediction.
  Assumes the instruction bus answers one cycle after a request and that
  the execution pipeline reports branch outcomes on the resolve port.
*/
`timescale 1ns/1ns
module ifbp_fetch (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic                           clk_en,
  output logic                                ibus_req,
  output logic [ifbp_pkg::ADDR_W-1:0]         ibus_addr,
  input  wire logic                           ibus_ack,
  input  wire logic [ifbp_pkg::OPW_W-1:0]     ibus_rdata,
  input  wire ifbp_pkg::ifbp_resolve_s        resolve,
  input  wire logic [1:0]                     ds_take,
  output ifbp_pkg::ifbp_insn_s                ds_insn0,
  output ifbp_pkg::ifbp_insn_s                ds_insn1,
  output logic [1:0]                          ds_valid,
  output logic                                ill_exc,
  output logic [7:0]                          ill_vector,
  output logic                                queue_ready
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ifbp_pkg::ifbp_fsm_e                      fsm;
    logic [ifbp_pkg::ADDR_W-1:0]              pc;
    ifbp_pkg::ifbp_stage_s                    c1;
    ifbp_pkg::ifbp_stage_s                    c2;
    logic                                     ed_v;
    ifbp_pkg::ifbp_insn_s                     ed;
    ifbp_pkg::ifbp_insn_s [ifbp_pkg::QUEUE_D-1:0] q;
    logic [ifbp_pkg::QPTR_W:0]                qcnt;
    ifbp_pkg::ifbp_bc_s   [ifbp_pkg::BC_N-1:0]    bc;
    logic [ifbp_pkg::PT_N-1:0][1:0]           pt;
    logic [ifbp_pkg::RS_N-1:0][ifbp_pkg::ADDR_W-1:0] rs;
    logic [ifbp_pkg::RS_PTR_W-1:0]            rsp;
    ifbp_pkg::ifbp_insn_s                     d0;
    ifbp_pkg::ifbp_insn_s                     d1;
    logic [1:0]                               dv;
    logic                                     ill;
    logic                                     req;
  } ifbp_state_s;

  ifbp_state_s s_r;
  ifbp_state_s s_nxt;

  function automatic logic [1:0] sat_step(input logic [1:0] p, input logic t);
    if (t) begin
      sat_step = (p == 2'(ifbp_pkg::IFBP_ST)) ? p : p + 2'b01;
    end else begin
      sat_step = (p == 2'(ifbp_pkg::IFBP_SNT)) ? p : p - 2'b01;
    end
  endfunction

  function automatic logic [ifbp_pkg::BC_IDX_W-1:0] bc_idx(input logic [31:0] a);
    bc_idx = a[ifbp_pkg::IDX_LSB +: ifbp_pkg::BC_IDX_W];
  endfunction

  function automatic logic [ifbp_pkg::PT_IDX_W-1:0] pt_idx(input logic [31:0] a);
    pt_idx = a[ifbp_pkg::IDX_LSB +: ifbp_pkg::PT_IDX_W];
  endfunction

  function automatic logic is_illegal(input logic [15:0] w);
    is_illegal = (w[15:12] == ifbp_pkg::OP_ILL_A) || (w[15:12] == ifbp_pkg::OP_ILL_F);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  ifbp_pkg::ifbp_bc_s           hit_e;
  logic                         bc_hit;
  logic                         bc_taken;
  logic [15:0]                  w;
  logic [ifbp_pkg::ADDR_W-1:0]  disp_tgt;
  logic                         is_bcc;
  logic                         is_bra;
  logic                         is_bsr;
  logic                         is_jsr;
  logic                         is_rts;
  logic                         ed_pred;
  logic                         ed_redir;
  logic [ifbp_pkg::ADDR_W-1:0]  ed_tgt;
  logic                         push;
  logic [ifbp_pkg::QPTR_W:0]    take_n;
  logic                         q_room;
  ifbp_pkg::ifbp_insn_s         cap;

  always_comb begin
    s_nxt    = s_r;
    hit_e    = s_r.bc[bc_idx(s_r.c1.addr)];
    bc_hit   = s_r.c1.valid && hit_e.valid && (hit_e.tag == s_r.c1.addr);
    bc_taken = bc_hit && hit_e.pred[1];
    w        = ibus_rdata;
    disp_tgt = s_r.c2.addr + ifbp_pkg::FETCH_STEP
               + {{24{w[ifbp_pkg::DISP_MSB]}}, w[ifbp_pkg::DISP_MSB:0]};
    is_bcc   = (w[15:12] == ifbp_pkg::OP_BCC);
    is_bra   = is_bcc && (w[11:8] == ifbp_pkg::COND_BRA);
    is_bsr   = is_bcc && (w[11:8] == ifbp_pkg::COND_BSR);
    is_jsr   = ((w & ifbp_pkg::OP_JMP_MSK) == ifbp_pkg::OP_JSR);
    is_rts   = (w == ifbp_pkg::OP_RTS);
    ed_pred  = is_bra || is_bsr || (is_bcc && s_r.pt[pt_idx(s_r.c2.addr)][1]);
    ed_tgt   = is_rts ? s_r.rs[s_r.rsp - 2'b01] : disp_tgt;
    ed_redir = s_r.c2.valid && ibus_ack && (ed_pred || is_rts);
    // Words still in flight need a slot too, or the queue overruns
    q_room   = ((s_r.qcnt + (ifbp_pkg::QPTR_W+1)'(s_r.c1.valid)
                 + (ifbp_pkg::QPTR_W+1)'(s_r.c2.valid) + (ifbp_pkg::QPTR_W+1)'(s_r.ed_v))
                < (ifbp_pkg::QPTR_W+1)'(ifbp_pkg::QUEUE_D));
    s_nxt.req = q_room;
    take_n   = (ifbp_pkg::QPTR_W+1)'(ds_take[0]) + (ifbp_pkg::QPTR_W+1)'(ds_take[1]);
    if (take_n > s_r.qcnt) begin
      take_n = s_r.qcnt;
    end
    // Dequeue into decode pair, shifting the queue down
    for (int i = 0; i < ifbp_pkg::QUEUE_D; i++) begin
      if (i + int'(take_n) < ifbp_pkg::QUEUE_D) begin
        s_nxt.q[i] = s_r.q[i + int'(take_n)];
      end
    end
    s_nxt.qcnt = s_r.qcnt - take_n;
    // Capture the early-decode output into the queue tail
    push = s_r.ed_v && !s_r.ed.folded;
    cap  = s_r.ed;
    if (push) begin
      s_nxt.q[s_nxt.qcnt] = cap;
      s_nxt.qcnt = s_nxt.qcnt + 1'b1;
    end
    // Decode registers: bypass when queue empty, else head of queue
    s_nxt.d0 = (s_nxt.qcnt != '0) ? s_nxt.q[0] : cap;
    s_nxt.d1 = s_nxt.q[1];
    s_nxt.dv = {s_nxt.qcnt > (ifbp_pkg::QPTR_W+1)'(1),
                (s_nxt.qcnt != '0)};
    s_nxt.ill = s_nxt.dv[0] && s_nxt.d0.illegal;
    // Fetch stages advance
    s_nxt.c1.valid = q_room;
    s_nxt.c1.addr  = s_r.pc;
    s_nxt.c2       = s_r.c1;
    s_nxt.c2.valid = s_r.c1.valid && !bc_taken;
    s_nxt.pc       = q_room ? s_r.pc + ifbp_pkg::FETCH_STEP : s_r.pc;
    s_nxt.ed_v     = s_r.c2.valid && ibus_ack;
    s_nxt.ed.addr  = s_r.c2.addr;
    s_nxt.ed.opw   = w;
    s_nxt.ed.is_branch  = is_bcc || is_jsr || is_rts;
    s_nxt.ed.pred_taken = ed_pred || is_rts;
    s_nxt.ed.target     = ed_tgt;
    s_nxt.ed.illegal    = is_illegal(w);
    s_nxt.ed.folded     = s_r.c2.valid && is_bcc && !is_bsr
                          && s_r.bc[bc_idx(s_r.c2.addr)].valid
                          && s_r.bc[bc_idx(s_r.c2.addr)].tag == s_r.c2.addr
                          && s_r.bc[bc_idx(s_r.c2.addr)].pred[1];
    if (s_nxt.ed_v && (is_bsr || is_jsr)) begin
      s_nxt.rs[s_r.rsp] = s_r.c2.addr + ifbp_pkg::FETCH_STEP;
      s_nxt.rsp = s_r.rsp + 2'b01;
    end else if (s_nxt.ed_v && is_rts) begin
      s_nxt.rsp = s_r.rsp - 2'b01;
    end
    // Redirects: early decode then branch cache, later stage wins
    if (ed_redir && !s_nxt.ed.folded) begin
      s_nxt.pc = ed_tgt;
      s_nxt.c1.valid = 1'b0;
      s_nxt.c2.valid = 1'b0;
    end else if (bc_taken) begin
      s_nxt.pc = hit_e.target;
      s_nxt.c1.valid = 1'b0;
    end
    // Training on resolution
    if (resolve.valid) begin
      s_nxt.pt[pt_idx(resolve.addr)] = sat_step(s_r.pt[pt_idx(resolve.addr)],
                                                resolve.taken);
      if (s_r.bc[bc_idx(resolve.addr)].tag == resolve.addr
          && s_r.bc[bc_idx(resolve.addr)].valid) begin
        s_nxt.bc[bc_idx(resolve.addr)].pred =
          sat_step(s_r.bc[bc_idx(resolve.addr)].pred, resolve.taken);
      end else if (resolve.taken) begin
        s_nxt.bc[bc_idx(resolve.addr)] = '{1'b1, resolve.addr,
                                          2'(ifbp_pkg::IFBP_WT), resolve.target};
      end
    end
    s_nxt.fsm = ifbp_pkg::IFBP_RUN;
    if (resolve.valid && resolve.mispredict) begin
      s_nxt.fsm = ifbp_pkg::IFBP_FLUSH;
      s_nxt.pc = resolve.taken ? resolve.target : resolve.addr + ifbp_pkg::FETCH_STEP;
      s_nxt.c1.valid = 1'b0;
      s_nxt.c2.valid = 1'b0;
      s_nxt.ed_v = 1'b0;
      s_nxt.qcnt = '0;
      s_nxt.dv = '0;
      s_nxt.ill = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r     <= '0;
      s_r.fsm <= ifbp_pkg::IFBP_RUN;
      s_r.pc  <= ifbp_pkg::RESET_PC;
      for (int i = 0; i < ifbp_pkg::PT_N; i++) begin
        s_r.pt[i] <= ifbp_pkg::PRED_RESET;
      end
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign ibus_req    = s_r.c1.valid;
  assign ibus_addr   = s_r.c1.addr;
  assign ds_insn0    = s_r.d0;
  assign ds_insn1    = s_r.d1;
  assign ds_valid    = s_r.dv;
  assign ill_exc     = s_r.ill;
  assign ill_vector  = ifbp_pkg::VEC_ILLEGAL;
  assign queue_ready = s_r.req;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_queue_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_r.qcnt <= (ifbp_pkg::QPTR_W+1)'(ifbp_pkg::QUEUE_D))
    else $error("queue over ten");
  a_flush_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && resolve.valid && resolve.mispredict |=> s_r.qcnt == '0 && !ds_valid[0])
    else $error("flush left entries");
  a_bc_redirect: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && bc_taken && !ed_redir && !resolve.valid |=> s_r.pc == $past(hit_e.target))
    else $error("cache hit not redirected");
  a_ill_vector: assert property (@(posedge clk_sys) disable iff (!resetn)
    ill_exc |-> ds_valid[0] && ds_insn0.illegal && ill_vector == 8'h04)
    else $error("illegal flag wrong");
  a_fetch_order: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && ibus_req && !bc_taken && !ed_redir && !resolve.valid |=> s_r.c2.valid)
    else $error("fetch two not started");
  a_dual_order: assert property (@(posedge clk_sys) disable iff (!resetn)
    ds_valid[1] |-> ds_valid[0])
    else $error("second slot without first");
  a_pc_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && q_room && !bc_taken && !ed_redir && !resolve.valid
    |=> s_r.pc == $past(s_r.pc) + 32'h0000_0002)
    else $error("pc step wrong");
  a_rs_push: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && s_nxt.ed_v && is_bsr && !resolve.valid |=> s_r.rsp == $past(s_r.rsp) + 2'b01)
    else $error("return stack not pushed");
endmodule

// ==== bench/ifbp_mem_model.sv ====
/*
  Instruction memory model for the fetch front end: answers every request
  on the next edge. Assumes the bench loads prog before reset is released.
*/
`timescale 1ns/1ns
module ifbp_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ibus_req,
  input  wire logic [31:0] ibus_addr,
  output logic             ibus_ack,
  output logic [15:0]      ibus_rdata
);
  logic [15:0] prog [0:255];

  // Idle cycles invert the held word on each edge, so a stale word shows again every second idle cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ibus_ack   <= 1'b0;
      ibus_rdata <= 16'h0000;
    end else if (ibus_req) begin
      ibus_ack   <= 1'b1;
      ibus_rdata <= prog[ibus_addr[8:1]];
    end else begin
      ibus_ack   <= 1'b0;
      ibus_rdata <= ~ibus_rdata;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the fetch front end.
  Assumes the memory model in ifbp_mem_model and a 20 MHz processor clock.
*/
`timescale 1ns/1ns
module tb_top;
  localparam logic [31:0] BR_AT  = 32'h0000_0020;
  localparam logic [31:0] BR_TGT = 32'h0000_0032;
  localparam logic [31:0] ILL_AT = 32'h0000_0036;
  localparam logic [31:0] FIX_AT = 32'h0000_0080;
  logic                    clk_sys;
  logic                    resetn;
  logic                    ibus_req;
  logic                    ibus_ack;
  logic                    ill_exc;
  logic                    queue_ready;
  logic [31:0]             ibus_addr;
  logic [15:0]             ibus_rdata;
  logic [1:0]              ds_take;
  logic [1:0]              ds_valid;
  logic [7:0]              ill_vector;
  ifbp_pkg::ifbp_resolve_s resolve;
  ifbp_pkg::ifbp_insn_s    ds_insn0;
  ifbp_pkg::ifbp_insn_s    ds_insn1;
  int                      fail_count;
  int                      checks_done;
  logic [31:0]             exp_pc;

  ifbp_fetch dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .ibus_req(ibus_req),
    .ibus_addr(ibus_addr), .ibus_ack(ibus_ack), .ibus_rdata(ibus_rdata), .resolve(resolve),
    .ds_take(ds_take), .ds_insn0(ds_insn0), .ds_insn1(ds_insn1), .ds_valid(ds_valid),
    .ill_exc(ill_exc), .ill_vector(ill_vector), .queue_ready(queue_ready));
  ifbp_mem_model mem (.clk_sys(clk_sys), .resetn(resetn), .ibus_req(ibus_req),
    .ibus_addr(ibus_addr), .ibus_ack(ibus_ack), .ibus_rdata(ibus_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] nxt(logic [31:0] a);
    return (a == BR_AT) ? BR_TGT : a + 32'h0000_0002;
  endfunction

  task automatic end_sim;
    $display("checks_done %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_valid(logic [1:0] need);
    int n;
    for (n = 0; n < 64; n++) begin
      @(negedge clk_sys);
      if ((ds_valid & need) === need) return;
    end
    fail_count++;
    $display("BAD %0t decode slots never filled", $time);
    end_sim();
  endtask

  task automatic take_one;
    wait_valid(2'b01);
    cmp(ds_insn0.addr, exp_pc, "slot0 addr");
    cmp({16'h0000, ds_insn0.opw}, {16'h0000, mem.prog[exp_pc[8:1]]}, "slot0 word");
    if (exp_pc == BR_AT) cmp({31'h0, ds_insn0.is_branch}, 32'h0000_0001, "branch mark");
    if (exp_pc == ILL_AT) begin
      cmp({31'h0, ill_exc}, 32'h0000_0001, "illegal flag");
      cmp({24'h0, ill_vector}, 32'h0000_0004, "illegal vector");
    end
    @(posedge clk_sys) ds_take <= 2'b01;
    @(posedge clk_sys) ds_take <= 2'b00;
    exp_pc = nxt(exp_pc);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    @(negedge clk_sys);
    cmp({31'h0, ibus_req}, 32'h0000_0000, "req in reset");
    cmp({30'h0, ds_valid}, 32'h0000_0000, "valid in reset");
    @(posedge clk_sys) resetn <= 1'b1;
    @(negedge clk_sys);
    cmp({31'h0, ibus_req}, 32'h0000_0000, "req at release");
    @(negedge clk_sys);
    cmp({31'h0, ibus_req}, 32'h0000_0001, "first request");
    cmp(ibus_addr, 32'h0000_0000, "first address");
  endtask

  task automatic t_stream;
    exp_pc = 32'h0000_0000;
    repeat (20) take_one();
    repeat (3) begin
      wait_valid(2'b11);
      cmp(ds_insn0.addr, exp_pc, "pair slot0");
      cmp(ds_insn1.addr, nxt(exp_pc), "pair slot1");
      @(posedge clk_sys) ds_take <= 2'b11;
      @(posedge clk_sys) ds_take <= 2'b00;
      exp_pc = nxt(nxt(exp_pc));
    end
  endtask

  task automatic t_fill;
    int reqs;
    reqs = 0;
    repeat (40) @(negedge clk_sys);
    cmp({31'h0, queue_ready}, 32'h0000_0000, "queue full");
    repeat (5) begin
      @(negedge clk_sys);
      reqs += int'(ibus_req);
    end
    cmp(32'(reqs), 32'h0000_0000, "fetch halted");
    repeat (14) take_one();
  endtask

  task automatic t_flush;
    int n;
    @(posedge clk_sys) begin
      resolve.valid <= 1'b1;
      resolve.addr <= exp_pc;
      resolve.taken <= 1'b1;
      resolve.mispredict <= 1'b1;
      resolve.target <= FIX_AT;
    end
    @(posedge clk_sys) resolve <= '0;
    for (n = 0; n < 8 && !(ibus_req === 1'b1 && ibus_addr === FIX_AT); n++)
      @(negedge clk_sys);
    if (n == 8) begin
      fail_count++;
      $display("BAD %0t restart request never seen", $time);
      end_sim();
    end
    cmp(ibus_addr, FIX_AT, "restart address");
    exp_pc = FIX_AT;
    repeat (4) take_one();
  endtask

  initial begin
    resetn = 1'b0;
    ds_take = 2'b00;
    resolve = '0;
    fail_count = 0;
    checks_done = 0;
    for (int i = 0; i < 256; i++) mem.prog[i] = 16'h4e71;
    mem.prog[BR_AT[8:1]] = 16'h6010;
    mem.prog[ILL_AT[8:1]] = 16'ha000;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_stream();
    t_fill();
    t_flush();
    end_sim();
  end
endmodule
